// ### shared/tfsd_pkg.sv
// Package: codes, status bit positions, register map and timing for decoder
package tfsd_pkg;
  // Function word classes (bits 5:3)
  localparam logic [2:0] CLASS_FORMAT = 3'h0;
  localparam logic [2:0] CLASS_MOTION = 3'h1;
  localparam logic [2:0] CLASS_INTR   = 3'h2;
  // Format codes
  localparam logic [11:0] FN_RELEASE  = 12'h000;
  localparam logic [11:0] FN_BINARY   = 12'h001;
  localparam logic [11:0] FN_CODED    = 12'h002;
  localparam logic [11:0] FN_D556     = 12'h003;
  localparam logic [11:0] FN_D200     = 12'h004;
  localparam logic [11:0] FN_CLEAR    = 12'h005;
  // Motion codes (octal 0010..0016)
  localparam logic [11:0] FN_REWIND   = 12'h008;
  localparam logic [11:0] FN_UNLOAD   = 12'h009;
  localparam logic [11:0] FN_BACKSP   = 12'h00A;
  localparam logic [11:0] FN_SRCH_FWD = 12'h00B;
  localparam logic [11:0] FN_SRCH_BWD = 12'h00C;
  localparam logic [11:0] FN_WR_MARK  = 12'h00D;
  localparam logic [11:0] FN_SKIP_BAD = 12'h00E;
  // Motion operation encodings presented to the tape unit
  localparam logic [2:0] OP_REWIND   = 3'h0;
  localparam logic [2:0] OP_UNLOAD   = 3'h1;
  localparam logic [2:0] OP_BACKSP   = 3'h2;
  localparam logic [2:0] OP_SRCH_FWD = 3'h3;
  localparam logic [2:0] OP_SRCH_BWD = 3'h4;
  localparam logic [2:0] OP_WR_MARK  = 3'h5;
  localparam logic [2:0] OP_SKIP_BAD = 3'h6;
  // File mark character (octal 17)
  localparam logic [5:0] FILE_MARK_CHAR = 6'h0F;
  // Status reply bit positions
  localparam int ST_FILE_MARK  = 4;
  localparam int ST_LOAD_POINT = 5;
  localparam int ST_D556       = 6;
  localparam int ST_D200       = 7;
  localparam int ST_LOST_DATA  = 8;
  localparam int ST_LONG_PAR   = 9;
  localparam int ST_VERT_PAR   = 10;
  localparam int ST_RES_REJ    = 11;
  // Register map (byte addresses)
  localparam logic [7:0] REG_FUNC    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_CONTROL = 8'h08;
  localparam logic [7:0] REG_EVENT   = 8'h0C;
  // Control register fields
  localparam int CTL_BINARY = 0;
  localparam int CTL_D556   = 1;
  localparam int CTL_D200   = 2;
  localparam int CTL_CONN   = 3;
  localparam int CTL_RESV   = 4;
  // Reset values
  localparam logic       RST_BINARY = 1'b1;
  localparam logic [1:0] RST_DENS   = 2'h0;
  // Parity reject wait before the computer rejects, in ns
  localparam int PAR_REJ_NS   = 100000;
  localparam int CLK_NS       = 10;
  localparam int PAR_REJ_CYC  = PAR_REJ_NS / CLK_NS;
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/tfsd_decoder.sv
// Module: tape function decoder, upper status bits and AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Longitudinal parity bit set on error, cleared
// - Chained longitudinal error holds until new operation
// - Vertical parity bit set, cleared on record
// - Chained vertical error clears on next record
// - File mark read in binary sets vertical
// - Reserve reject shows last connect refusal
// - Bits 5..3 select format, motion, interrupt
// - Accept only connected; parity error line
// - Other unit may connect while first runs
// - Rewind to load point, none at point
// - Rewind unload locks unit until reload
// - Backspace one record, limits at load point; decoder launches backspace even at load point
// - Backspaces may run on several units
// - File mark search, stop at markers
// - Write mark octal 17, format unchanged
// - Skip bad spot erases, reports, interrupts
// - Motion codes rejected while control busy
// - Release drops connection and own reservation
// - Binary: odd transverse, even longitudinal
// - Coded: even transverse parity, same checks
// - Density codes select 556 or 200
// - Clear drops connection and all reservations
// - Status request returns 12-bit reply
// - Legal function clears lost data
module tfsd_decoder #(
  parameter int UNITS = 16
) (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // Tape side
  input  wire logic        master_clear_in,
  input  wire logic        channel_clear_in,
  input  wire logic        connect_in,
  input  wire logic [3:0]  connect_unit_in,
  input  wire logic        connect_reject_in,
  input  wire logic        func_par_err_in,
  input  wire logic        rw_busy_in,
  input  wire logic        record_start_in,
  input  wire logic        op_start_in,
  input  wire logic        chain_in,
  input  wire logic        long_err_in,
  input  wire logic        vert_err_in,
  input  wire logic        mark_read_in,
  input  wire logic        at_load_point_in,
  input  wire logic        reloaded_in,
  input  wire logic        lost_data_in,
  input  wire logic        eoi_select_in,
  input  wire logic        op_done_in,
  output logic             motion_go_out,
  output logic [2:0]       motion_op_out,
  output logic [3:0]       motion_unit_out,
  output logic             par_err_line_out,
  output logic             func_reject_out,
  output logic             odd_parity_out,
  output logic             dens_556_out,
  output logic             dens_200_out,
  output logic [5:0]       mark_char_out,
  output logic             intr_sel_out,
  output logic             eoo_intr_out,
  output logic [11:0]      status_out
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wr_fire;
  logic [11:0] status_w;
  logic [31:0] ctl_w;

  assign wr_fire = aw_q && w_q && !s_axi_bvalid_out;

  // Address and data taken in either order, answered after both
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      aw_q              <= 1'b0;
      w_q               <= 1'b0;
      awaddr_q          <= 8'h00;
      wdata_q           <= 32'h0000_0000;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'h0;
    end else begin
      s_axi_awready_out <= !aw_q && !s_axi_awready_out && !s_axi_bvalid_out;
      s_axi_wready_out  <= !w_q && !s_axi_wready_out && !s_axi_bvalid_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_q             <= 1'b0;
        w_q              <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= (awaddr_q == tfsd_pkg::REG_FUNC) ?
                            tfsd_pkg::RESP_OKAY : tfsd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // Read channel; status copy returns the 12-bit reply
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= 2'h0;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rresp_out   <= tfsd_pkg::RESP_OKAY;
        unique case (s_axi_araddr_in)
          tfsd_pkg::REG_STATUS:  s_axi_rdata_out <= {20'h0_0000, status_w};
          tfsd_pkg::REG_CONTROL: s_axi_rdata_out <= ctl_w;
          tfsd_pkg::REG_FUNC:    s_axi_rdata_out <= 32'h0000_0000;
          tfsd_pkg::REG_EVENT:   s_axi_rdata_out <= {31'h0, func_reject_out};
          default: begin
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= tfsd_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Function decode
  // ----------------------------------------------------------------
  logic        func_wr;
  logic [11:0] fw;
  logic        connected_q;
  logic [3:0]  unit_q;
  logic [UNITS-1:0] resv_q;
  logic [UNITS-1:0] locked_q;
  logic        is_motion, is_format, is_intr, legal;
  logic        clr_all;

  assign func_wr = wr_fire && (awaddr_q == tfsd_pkg::REG_FUNC);
  assign fw      = wdata_q[11:0];
  assign clr_all = master_clear_in || channel_clear_in;

  // Classify by octal digit in bits 5..3
  assign is_format = (fw[5:3] == tfsd_pkg::CLASS_FORMAT) && fw[11:6] == 6'h00
                     && fw[2:0] <= 3'h5;
  assign is_motion = (fw[5:3] == tfsd_pkg::CLASS_MOTION) && fw[11:6] == 6'h00
                     && fw[2:0] <= 3'h6;
  assign is_intr   = (fw[5:3] == tfsd_pkg::CLASS_INTR) && fw[11:6] == 6'h00;
  assign legal     = is_format || is_motion || is_intr;

  logic accept;
  // Accepted only when connected and no transmission parity error
  assign accept = func_wr && connected_q && !func_par_err_in;

  // Connection and reservations
  always_ff @(posedge clock_in) begin
    if (rst_in || clr_all) begin
      connected_q <= 1'b0;
      unit_q      <= 4'h0;
      resv_q      <= '0;
    end else if (connect_in && !connect_reject_in) begin
      // Reconnecting leaves other units running
      connected_q      <= 1'b1;
      unit_q           <= connect_unit_in;
      resv_q[connect_unit_in] <= 1'b1;
    end else if (accept && fw == tfsd_pkg::FN_RELEASE && !rw_busy_in) begin
      connected_q    <= 1'b0;
      resv_q[unit_q] <= 1'b0;
    end else if (accept && fw == tfsd_pkg::FN_CLEAR && !rw_busy_in) begin
      connected_q <= 1'b0;
      resv_q      <= '0;
    end
  end

  // Reserve reject reflects the last connect attempt
  logic res_rej_q;
  always_ff @(posedge clock_in) begin
    if (rst_in || master_clear_in) res_rej_q <= 1'b0;
    else if (connect_in) res_rej_q <= connect_reject_in;
  end

  // Unload lockout per unit until manual reload
  always_ff @(posedge clock_in) begin
    if (rst_in) locked_q <= '0;
    else begin
      if (reloaded_in) locked_q[unit_q] <= 1'b0;
      if (accept && fw == tfsd_pkg::FN_UNLOAD && !rw_busy_in
          && !locked_q[unit_q])
        locked_q[unit_q] <= 1'b1;
    end
  end

  // Format and density; all clears except release return to binary
  logic binary_q, d556_q, d200_q;
  always_ff @(posedge clock_in) begin
    if (rst_in || clr_all) begin
      binary_q <= tfsd_pkg::RST_BINARY;
      {d556_q, d200_q} <= tfsd_pkg::RST_DENS;
    end else if (accept && is_format && !rw_busy_in) begin
      unique case (fw)
        tfsd_pkg::FN_BINARY: binary_q <= 1'b1;
        tfsd_pkg::FN_CODED:  binary_q <= 1'b0;
        tfsd_pkg::FN_D556: begin
          d556_q <= 1'b1;
          d200_q <= 1'b0;
        end
        tfsd_pkg::FN_D200: begin
          d556_q <= 1'b0;
          d200_q <= 1'b1;
        end
        tfsd_pkg::FN_CLEAR: binary_q <= 1'b1;
        default: ;
      endcase
    end
  end

  // Motion command launch, busy reject and locked units
  logic motion_ok;
  assign motion_ok = accept && is_motion && !rw_busy_in
                     && !locked_q[unit_q]
                     && !(fw == tfsd_pkg::FN_REWIND && at_load_point_in);
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      motion_go_out   <= 1'b0;
      motion_op_out   <= 3'h0;
      motion_unit_out <= 4'h0;
      mark_char_out   <= 6'h00;
      func_reject_out <= 1'b0;
    end else begin
      motion_go_out   <= motion_ok;
      func_reject_out <= func_wr && (!connected_q || !legal
                         || ((is_motion || is_format) && rw_busy_in)
                         || (is_motion && locked_q[unit_q]));
      if (motion_ok) begin
        motion_op_out   <= fw[2:0];
        motion_unit_out <= unit_q;
        mark_char_out   <= (fw == tfsd_pkg::FN_WR_MARK) ?
                           tfsd_pkg::FILE_MARK_CHAR : 6'h00;
      end
    end
  end

  // Parity error line held for the reject wait
  localparam int PW = $clog2(tfsd_pkg::PAR_REJ_CYC + 1);
  logic [PW-1:0] par_cnt_q;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      par_cnt_q        <= '0;
      par_err_line_out <= 1'b0;
    end else begin
      if (func_wr && connected_q && func_par_err_in) begin
        par_cnt_q        <= PW'(tfsd_pkg::PAR_REJ_CYC);
        par_err_line_out <= 1'b1;
      end else if (par_cnt_q != '0) begin
        par_cnt_q        <= par_cnt_q - PW'(1);
        par_err_line_out <= (par_cnt_q != PW'(1));
      end
    end
  end

  // Transverse parity; write mark always even, format unchanged
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      odd_parity_out <= 1'b1;
      dens_556_out   <= 1'b0;
      dens_200_out   <= 1'b0;
    end else begin
      odd_parity_out <= binary_q && !(motion_go_out
                        && motion_op_out == tfsd_pkg::OP_WR_MARK);
      dens_556_out   <= d556_q;
      dens_200_out   <= d200_q;
    end
  end

  // Interrupt selection and end of skip bad spot event
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      intr_sel_out <= 1'b0;
      eoo_intr_out <= 1'b0;
    end else begin
      intr_sel_out <= accept && is_intr;
      eoo_intr_out <= op_done_in && eoi_select_in
                      && motion_op_out == tfsd_pkg::OP_SKIP_BAD;
    end
  end

  // ----------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------
  logic long_q, vert_q, lost_q, fm_q;

  // Longitudinal: chain holds until a new operation starts
  always_ff @(posedge clock_in) begin
    if (rst_in || clr_all) long_q <= 1'b0;
    else if (long_err_in) long_q <= 1'b1;
    else if (op_start_in || (record_start_in && !chain_in))
      long_q <= 1'b0;
  end

  // Vertical: new record or new operation clears; mark in binary sets
  always_ff @(posedge clock_in) begin
    if (rst_in || clr_all) vert_q <= 1'b0;
    else if (vert_err_in || (mark_read_in && binary_q))
      vert_q <= 1'b1;
    else if (op_start_in || record_start_in) vert_q <= 1'b0;
  end

  // Lost data cleared by any accepted legal function
  always_ff @(posedge clock_in) begin
    if (rst_in || clr_all) lost_q <= 1'b0;
    else if (lost_data_in) lost_q <= 1'b1;
    else if (accept && legal) lost_q <= 1'b0;
  end

  // File mark found by a search
  always_ff @(posedge clock_in) begin
    if (rst_in || clr_all) fm_q <= 1'b0;
    else if (op_done_in && (motion_op_out == tfsd_pkg::OP_SRCH_FWD
             || motion_op_out == tfsd_pkg::OP_SRCH_BWD) && mark_read_in)
      fm_q <= 1'b1;
    else if (motion_ok || record_start_in) fm_q <= 1'b0;
  end

  always_comb begin
    status_w = 12'h000;
    status_w[tfsd_pkg::ST_FILE_MARK]  = fm_q;
    status_w[tfsd_pkg::ST_LOAD_POINT] = at_load_point_in;
    status_w[tfsd_pkg::ST_D556]       = d556_q;
    status_w[tfsd_pkg::ST_D200]       = d200_q;
    status_w[tfsd_pkg::ST_LOST_DATA]  = lost_q;
    status_w[tfsd_pkg::ST_LONG_PAR]   = long_q;
    status_w[tfsd_pkg::ST_VERT_PAR]   = vert_q;
    status_w[tfsd_pkg::ST_RES_REJ]    = res_rej_q;
    ctl_w = 32'h0000_0000;
    ctl_w[tfsd_pkg::CTL_BINARY] = binary_q;
    ctl_w[tfsd_pkg::CTL_D556]   = d556_q;
    ctl_w[tfsd_pkg::CTL_D200]   = d200_q;
    ctl_w[tfsd_pkg::CTL_CONN]   = connected_q;
    ctl_w[tfsd_pkg::CTL_RESV]   = resv_q[unit_q];
  end

  // Status output registered
  always_ff @(posedge clock_in) begin
    if (rst_in) status_out <= 12'h000;
    else status_out <= status_w;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_long_err;
    long_err_in && !rst_in && !clr_all;
  endsequence

  chk_long_set: assert property (@(posedge clock_in) disable iff (rst_in)
    s_long_err |=> long_q) else $error("long parity not set");
  chk_long_chain: assert property (@(posedge clock_in) disable iff (rst_in)
    long_q && chain_in && record_start_in && !op_start_in && !clr_all
    |=> long_q) else $error("long parity dropped in chain");
  chk_vert_set: assert property (@(posedge clock_in) disable iff (rst_in)
    !clr_all && (vert_err_in || (mark_read_in && binary_q)) |=> vert_q)
    else $error("vertical parity not set");
  chk_vert_clr: assert property (@(posedge clock_in) disable iff (rst_in)
    record_start_in && !vert_err_in && !mark_read_in |=> !vert_q)
    else $error("vertical parity not cleared");
  chk_res_rej: assert property (@(posedge clock_in) disable iff (rst_in)
    connect_in && !master_clear_in |=> res_rej_q == $past(connect_reject_in))
    else $error("reserve reject wrong");
  chk_busy_rej: assert property (@(posedge clock_in) disable iff (rst_in)
    func_wr && is_motion && rw_busy_in |=> !motion_go_out && func_reject_out)
    else $error("motion accepted while busy");
  chk_par_line: assert property (@(posedge clock_in) disable iff (rst_in)
    func_wr && connected_q && func_par_err_in |=> par_err_line_out[*8])
    else $error("parity line not held");
  chk_lost_clr: assert property (@(posedge clock_in) disable iff (rst_in)
    accept && legal && !lost_data_in |=> !lost_q)
    else $error("lost data not cleared");

endmodule

// ### bench/tfsd_tape_model.sv
// Tape unit stand-in that finishes each motion after a set delay
`timescale 1ns/1ps
module tfsd_tape_model (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       go_in,
  input  wire logic [7:0] delay_in,
  output logic            done_out
);
  logic [7:0] cnt_q;
  logic       run_q;
  // Motion runs for delay_in + 1 cycles, then completion pulse
  always_ff @(posedge clock_in) begin
    done_out <= 1'b0;
    if (rst_in) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (go_in) begin
      run_q <= 1'b1;
      cnt_q <= delay_in;
    end else if (run_q) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h00) begin
        run_q    <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end
endmodule

// ### bench/tape_function_status_decoder_bench.sv
// Self-checking bench for the tape function and status decoder
`timescale 1ns/1ps
module tape_function_status_decoder_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk, rst, awv, wv, awr, wrd, bv, bry, arv, arr, rv, rry;
  logic [7:0]  aa, ra, dly;
  logic [31:0] wd, rdt, d;
  logic [1:0]  brs, rrs, r;
  logic [8:0]  pl;
  logic        conn, rej, perr, busy, chain, atlp, eois, done, fmt;
  logic        go, frej, perl, oddp, d556, d200, isel, eoo;
  logic [3:0]  unit, mu, lu, u;
  logic [2:0]  op, lo;
  logic [5:0]  mch;
  logic [11:0] st, c;
  int          num_errors, checked, cyc, seed, gos, rejs, isels, eoos;
  int          k, ng;
  tfsd_decoder uut (
    .clock_in(clk), .rst_in(rst), .s_axi_awaddr_in(aa),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
    .s_axi_bresp_out(brs), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
    .s_axi_araddr_in(ra), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdt), .s_axi_rresp_out(rrs), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rry), .master_clear_in(pl[8]),
    .channel_clear_in(pl[7]), .connect_in(conn), .connect_unit_in(unit),
    .connect_reject_in(rej), .func_par_err_in(perr), .rw_busy_in(busy),
    .record_start_in(pl[0]), .op_start_in(pl[1]), .chain_in(chain),
    .long_err_in(pl[2]), .vert_err_in(pl[3]), .mark_read_in(pl[4]),
    .at_load_point_in(atlp), .reloaded_in(pl[6]), .lost_data_in(pl[5]),
    .eoi_select_in(eois), .op_done_in(done), .motion_go_out(go),
    .motion_op_out(op), .motion_unit_out(mu), .par_err_line_out(perl),
    .func_reject_out(frej), .odd_parity_out(oddp), .dens_556_out(d556),
    .dens_200_out(d200), .mark_char_out(mch), .intr_sel_out(isel),
    .eoo_intr_out(eoo), .status_out(st)
  );
  tfsd_tape_model tape (
    .clock_in(clk), .rst_in(rst), .go_in(go), .delay_in(dly),
    .done_out(done)
  );
  // ----------------------------------------
  // Clock, event counters and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    gos <= gos + int'(go);
    rejs <= rejs + int'(frej);
    isels <= isels + int'(isel);
    eoos <= eoos + int'(eoo);
    if (go === 1'b1) begin
      lo <= op;
      lu <= mu;
    end
    if (cyc == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [11:0] v);
    @(posedge clk);
    aa <= a;
    wd <= {20'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = brs;
    bry <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    ra <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdt;
    r = rrs;
    rry <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pl[i] <= 1'b1;
    @(posedge clk);
    pl[i] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic link(input logic [3:0] un, input logic rj);
    @(posedge clk);
    unit <= un;
    rej <= rj;
    conn <= 1'b1;
    @(posedge clk);
    conn <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic sb(input int b, input logic e);
    rd(tfsd_pkg::REG_STATUS);
    check("status bit", 32'(d[b]), 32'(e));
    check("status out", 32'(st[b]), 32'(e));
  endtask
  task automatic fn(input logic [11:0] v, input int dg);
    ng = gos + dg;
    wr(tfsd_pkg::REG_FUNC, v);
    for (k = 0; k < 300 && (gos > ng - dg) && done !== 1'b1; k++)
      @(posedge clk);
    @(posedge clk);
    check("motion count", gos, ng);
  endtask
  function automatic logic [2:0] exp_op(input logic [11:0] v);
    return 3'(v - tfsd_pkg::FN_REWIND);
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 96046;
    {num_errors, checked, cyc, gos, rejs, isels, eoos} = '0;
    {rst, awv, wv, bry, arv, rry, conn, rej, perr, busy} = 10'h200;
    {chain, atlp, eois, aa, ra, wd, pl, unit} = '0;
    dly = 8'h05;
    fmt = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h08);
    check("control", d & 32'hF, 32'h1);
    rd(8'h10);
    check("unmapped", 32'(r), 32'(tfsd_pkg::RESP_SLVERR));
    wr(tfsd_pkg::REG_STATUS, 12'h001);
    check("ro write", 32'(r), 32'(tfsd_pkg::RESP_SLVERR));
    wr(tfsd_pkg::REG_FUNC, 12'h001);
    check("unlinked", rejs, 1);
    u = 4'($random(seed));
    link(u, 1'b1);
    sb(tfsd_pkg::ST_RES_REJ, 1'b1);
    link(u, 1'b0);
    sb(tfsd_pkg::ST_RES_REJ, 1'b0);
    for (int i = 0; i < 8; i++) begin
      c = 12'h001 + 12'($random(seed) & 3);
      wr(tfsd_pkg::REG_FUNC, c);
      if (c < 12'h003) fmt = (c == tfsd_pkg::FN_BINARY);
      check("format", 32'(oddp), 32'(fmt));
      if (c > 12'h002) check("density", {d556, d200}, {c[0], ~c[0]});
    end
    wr(tfsd_pkg::REG_FUNC, tfsd_pkg::FN_D556);
    sb(tfsd_pkg::ST_D556, 1'b1);
    wr(tfsd_pkg::REG_FUNC, tfsd_pkg::FN_BINARY);
    atlp <= 1'b1;
    fn(tfsd_pkg::FN_REWIND, 0);
    sb(tfsd_pkg::ST_LOAD_POINT, 1'b1);
    atlp <= 1'b0;
    for (c = 12'h008; c < 12'h00E; c++) begin
      dly <= 8'($random(seed) & 8'h1F);
      fn(c, 1);
      check("motion op", lo, exp_op(c));
      // Unload locks the unit; hand reload frees it for the next code
      if (c == tfsd_pkg::FN_UNLOAD) pulse(6);
    end
    check("mark char", mch, tfsd_pkg::FILE_MARK_CHAR);
    check("format kept", oddp, 1'b1);
    link(u, 1'b0);
    busy <= 1'b1;
    fn(tfsd_pkg::FN_SKIP_BAD, 0);
    busy <= 1'b0;
    eois <= 1'b1;
    fn(tfsd_pkg::FN_SKIP_BAD, 1);
    repeat (5) @(posedge clk);
    check("end of op", eoos, 1);
    dly <= 8'h60;
    fn(tfsd_pkg::FN_BACKSP, 1);
    link(u + 4'h1, 1'b0);
    fn(tfsd_pkg::FN_BACKSP, 1);
    check("second unit", lu, 4'(u + 4'h1));
    wr(tfsd_pkg::REG_FUNC, 12'h010);
    check("intr class", isels, 1);
    pulse(2);
    sb(tfsd_pkg::ST_LONG_PAR, 1'b1);
    pulse(0);
    sb(tfsd_pkg::ST_LONG_PAR, 1'b0);
    chain <= 1'b1;
    pulse(2);
    pulse(3);
    pulse(0);
    sb(tfsd_pkg::ST_LONG_PAR, 1'b1);
    sb(tfsd_pkg::ST_VERT_PAR, 1'b0);
    pulse(1);
    sb(tfsd_pkg::ST_LONG_PAR, 1'b0);
    chain <= 1'b0;
    pulse(4);
    sb(tfsd_pkg::ST_VERT_PAR, 1'b1);
    pulse(7);
    sb(tfsd_pkg::ST_VERT_PAR, 1'b0);
    pulse(5);
    sb(tfsd_pkg::ST_LOST_DATA, 1'b1);
    link(u, 1'b0);
    wr(tfsd_pkg::REG_FUNC, tfsd_pkg::FN_BINARY);
    sb(tfsd_pkg::ST_LOST_DATA, 1'b0);
    perr <= 1'b1;
    wr(tfsd_pkg::REG_FUNC, tfsd_pkg::FN_CODED);
    perr <= 1'b0;
    check("par line", perl, 1'b1);
    repeat (tfsd_pkg::PAR_REJ_CYC + 10) @(posedge clk);
    check("par line end", perl, 1'b0);
    fn(tfsd_pkg::FN_UNLOAD, 1);
    fn(tfsd_pkg::FN_BACKSP, 0);
    pulse(6);
    fn(tfsd_pkg::FN_BACKSP, 1);
    wr(tfsd_pkg::REG_FUNC, tfsd_pkg::FN_RELEASE);
    rd(8'h08);
    check("released", 32'(d[3]), 32'h0);
    link(u, 1'b0);
    wr(tfsd_pkg::REG_FUNC, tfsd_pkg::FN_CLEAR);
    rd(8'h08);
    check("cleared", d & 32'h18, 32'h0);
    pulse(2);
    pulse(8);
    sb(tfsd_pkg::ST_LONG_PAR, 1'b0);
    end_of_test();
  end
endmodule
